//--- logic/dadc_comparator.sv
// debug address/data comparator bank with apb configuration
// assumes bus and pc inputs synchronous to clk_i, one event per cycle
//
// Overview of operation
// [R1] exact address match outside range modes
// [R2] optional read-only or write-only qualification
// [R3] any access covering programmed byte matches
// [R4] opcode mode compares pc, ignores data, direction
// [R5] software programs first opcode byte address
// [R6] only channels zero and two compare data
// [R7] data compared without any validity check
// [R8] boundary-crossing access evaluated as two parts
// [R9] low address bits select compare byte lane
// [R10] lane mapping fixed for every access size
// [R11] software masks other bytes for byte match
// [R12] unmasked field matches only full 32-bit access in equivalence mode
// [R13] software programs lowest byte, all masks set
// [R14] equivalence mode: masked bits must be equal
// [R15] equivalence with zero mask: address only
// [R16] difference mode: any masked bit differs
// [R17] difference with zero mask never matches
// [R18] untouched bytes skipped in difference mode, fail equivalence if masked in
// [R19] mask zero ignores bit, one compares it
// [R20] direction select zero writes, one reads
// [R21] cleared enable bit gives no match
// [R22] 24-bit address compared bit by bit
// [R23] channel outputs map to match events in order
// [R24] match is one-cycle pulse per event
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "dadc_defs.svh"

module dadc_comparator
	import dadc_pkg::*;
#(
	parameter int NUM_CH = `DADC_MAX_CH,
	parameter logic [`DADC_MAX_CH-1:0] DATA_CH_MASK = `DADC_DATA_CH
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire dadc_bus_t bus_i,
	input wire dadc_pc_t pc_i,
	input wire dadc_apb_req_t apb_i,
	output logic [`DADC_DW-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic [NUM_CH-1:0] match_o
);

	// ********************************************
	// parameter check
	// ********************************************
	generate
		if (NUM_CH < 1 || NUM_CH > `DADC_MAX_CH)
		begin : g_bad_ch
			$error("dadc_comparator: NUM_CH out of range");
		end
	endgenerate

	dadc_state_t st_r;
	dadc_state_t st_nxt;
	logic mapped;

	// ********************************************
	// helpers
	// ********************************************
	function automatic logic dir_ok(input dadc_cfg_t c, input logic wr);
		// select 0 keeps writes, 1 keeps reads
		return !c.direction_qualify_enable || // see [R2]
			(c.direction_select ? !wr : wr); // see [R20]
	endfunction

	// one aligned word part of an access; lanes marks touched bytes
	function automatic logic part_hit(
		input dadc_cfg_t c,
		input logic [`DADC_AW-3:0] word,
		input logic [3:0] lanes,
		input logic [0:3][7:0] d,
		input logic has_data
	);
		logic eq_ok;
		logic diff;
		logic [7:0] x;
		eq_ok = 1'b1;
		diff = 1'b0;
		for (int k = 0; k < 4; k++)
		begin
			// no validity check on the data, whatever is on the bus counts
			x = (d[k] ^ c.data_compare_byte[k]) & c.data_compare_mask[k]; // see [R7] [R19]
			if (lanes[k])
			begin
				eq_ok = eq_ok & (x == 8'h00); // see [R14]
				diff = diff | (|x); // see [R16]
			end
			else
			begin
				// untouched byte: ignored for difference, fails if masked in
				eq_ok = eq_ok & (c.data_compare_mask[k] == 8'h00); // see [R12] [R18]
			end
		end
		return (c.comparator_address_value[`DADC_AW-1:2] == word) && // see [R22]
			lanes[c.comparator_address_value[1:0]] && // see [R3]
			(!has_data || // see [R6]
			(c.mismatch_mode_select ? diff : eq_ok)); // see [R15] [R17]
	endfunction

	// ********************************************
	// next state
	// ********************************************
	always_comb
	begin
		logic [2:0] nb;
		logic [2:0] pos;
		logic [7:0] byt;
		logic [3:0] lanes_a;
		logic [3:0] lanes_b;
		logic [0:3][7:0] dat_a;
		logic [0:3][7:0] dat_b;
		logic [`DADC_AW-3:0] word_a;
		logic [`DADC_MAX_CH-1:0] hit;
		logic size_ok;
		logic [1:0] idx;
		logic [31:0] rd;
		dadc_cfg_t cf;
		nb = 3'h1 << bus_i.size;
		pos = 3'h0;
		byt = 8'h00;
		lanes_a = 4'h0;
		lanes_b = 4'h0;
		dat_a = '0;
		dat_b = '0;
		word_a = bus_i.addr[`DADC_AW-1:2];
		hit = '0;
		size_ok = (bus_i.size != 2'h3);
		idx = apb_i.paddr[5:4];
		rd = 32'h00000000;
		cf = '0;
		st_nxt = st_r;

		// lane of each byte follows its address, not its place in the access
		for (int i = 0; i < 4; i++)
		begin
			pos = 3'(bus_i.addr[1:0]) + 3'(i);
			byt = 8'(bus_i.data >> (8 * (int'(nb) - 1 - i)));
			if (3'(i) < nb)
			begin
				// bytes past the word end go to the next word's part
				if (!pos[2])
				begin
					lanes_a[pos[1:0]] = 1'b1; // see [R9] [R10]
					dat_a[pos[1:0]] = byt;
				end
				else
				begin
					lanes_b[pos[1:0]] = 1'b1; // see [R8]
					dat_b[pos[1:0]] = byt;
				end
			end
		end

		for (int c = 0; c < NUM_CH; c++)
		begin
			cf = st_r.ch[c];
			if (cf.opcode_match_select)
				hit[c] = cf.comparator_enable && pc_i.valid && // see [R4]
					(pc_i.addr == cf.comparator_address_value); // see [R1]
			else
				hit[c] = cf.comparator_enable && bus_i.valid && size_ok && // see [R21]
					dir_ok(cf, bus_i.write) &&
					(part_hit(cf, word_a, lanes_a, dat_a, DATA_CH_MASK[c]) ||
					part_hit(cf, 22'(word_a + 22'h1), lanes_b, dat_b,
					DATA_CH_MASK[c])); // see [R8]
		end
		st_nxt.match = hit; // see [R23] [R24]

		// register read mux
		case (apb_i.paddr[3:2])
			`DADC_REG_CTL:
			begin
				cf = st_r.ch[idx];
				rd[`DADC_CTL_EN] = cf.comparator_enable;
				rd[`DADC_CTL_OPC] = cf.opcode_match_select;
				rd[`DADC_CTL_DQE] = cf.direction_qualify_enable;
				rd[`DADC_CTL_DSEL] = cf.direction_select;
				rd[`DADC_CTL_MISM] = cf.mismatch_mode_select;
			end
			`DADC_REG_ADDR:
				rd = 32'(st_r.ch[idx].comparator_address_value);
			`DADC_REG_DATA:
				rd = st_r.ch[idx].data_compare_byte;
			`DADC_REG_MASK:
				rd = st_r.ch[idx].data_compare_mask;
			default:
				rd = 32'h00000000;
		endcase
		if (apb_i.paddr == `DADC_OFS_STATUS)
			rd = 32'(st_r.sticky);
		if (!mapped)
			rd = 32'h00000000;

		// read data captured in setup so it leaves a flop in the access phase
		if (apb_i.psel && !apb_i.penable)
			st_nxt.prdata = rd;

		// sticky status: a new hit wins over a same-cycle clear
		st_nxt.sticky = st_r.sticky;
		if (apb_i.psel && apb_i.penable && apb_i.pwrite &&
			apb_i.paddr == `DADC_OFS_STATUS)
			st_nxt.sticky = st_r.sticky & ~apb_i.pwdata[`DADC_MAX_CH-1:0];
		st_nxt.sticky = st_nxt.sticky | hit;

		if (apb_i.psel && apb_i.penable && apb_i.pwrite && mapped &&
			apb_i.paddr[7:6] == 2'h0)
		begin
			case (apb_i.paddr[3:2])
				`DADC_REG_CTL:
				begin
					st_nxt.ch[idx].comparator_enable =
						apb_i.pwdata[`DADC_CTL_EN];
					st_nxt.ch[idx].opcode_match_select =
						apb_i.pwdata[`DADC_CTL_OPC];
					st_nxt.ch[idx].direction_qualify_enable =
						apb_i.pwdata[`DADC_CTL_DQE];
					st_nxt.ch[idx].direction_select =
						apb_i.pwdata[`DADC_CTL_DSEL];
					// mode bit only exists where a data comparator exists
					st_nxt.ch[idx].mismatch_mode_select =
						apb_i.pwdata[`DADC_CTL_MISM] & DATA_CH_MASK[idx];
				end
				`DADC_REG_ADDR:
					st_nxt.ch[idx].comparator_address_value =
						apb_i.pwdata[`DADC_AW-1:0];
				`DADC_REG_DATA:
					if (DATA_CH_MASK[idx])
						st_nxt.ch[idx].data_compare_byte = apb_i.pwdata;
				`DADC_REG_MASK:
					if (DATA_CH_MASK[idx]) // see [R6]
						st_nxt.ch[idx].data_compare_mask = apb_i.pwdata;
				default: ;
			endcase
		end
	end

	assign mapped = (apb_i.paddr[1:0] == 2'h0) &&
		((apb_i.paddr[7:6] == 2'h0 && int'(apb_i.paddr[5:4]) < NUM_CH) ||
		apb_i.paddr == `DADC_OFS_STATUS);

	// ********************************************
	// state register
	// ********************************************
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			st_r <= '0;
			for (int c = 0; c < `DADC_MAX_CH; c++)
			begin
				st_r.ch[c].comparator_address_value <= `DADC_RST_ADDR;
				st_r.ch[c].data_compare_byte <= `DADC_RST_DATA;
				st_r.ch[c].data_compare_mask <= `DADC_RST_MASK;
			end
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// zero wait states; error only for unmapped access phases
	assign pready_o = 1'b1;
	assign pslverr_o = apb_i.psel && apb_i.penable && !mapped;
	assign prdata_o = st_r.prdata;
	assign match_o = st_r.match[NUM_CH-1:0];

	// ********************************************
	// checks
	// ********************************************
	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_chk
		a_enable_gate: // see [R21]
		assert property (@(posedge clk_i) disable iff (!rst_b_i)
			!st_r.ch[g].comparator_enable |=> !match_o[g])
			else $error("match while channel disabled");
		a_opcode_hit: // see [R4]
		assert property (@(posedge clk_i) disable iff (!rst_b_i)
			st_r.ch[g].comparator_enable &&
			st_r.ch[g].opcode_match_select && pc_i.valid &&
			pc_i.addr == st_r.ch[g].comparator_address_value
			|=> match_o[g])
			else $error("opcode address match missed");
		a_write_only: // see [R20]
		assert property (@(posedge clk_i) disable iff (!rst_b_i)
			!st_r.ch[g].opcode_match_select &&
			st_r.ch[g].direction_qualify_enable &&
			!st_r.ch[g].direction_select && bus_i.valid && !bus_i.write
			|=> !match_o[g])
			else $error("read matched in write-only mode");
		a_cover_word: // see [R3]
		assert property (@(posedge clk_i) disable iff (!rst_b_i)
			st_r.ch[g].comparator_enable &&
			!st_r.ch[g].opcode_match_select &&
			!st_r.ch[g].direction_qualify_enable &&
			!st_r.ch[g].mismatch_mode_select &&
			st_r.ch[g].data_compare_mask == '0 && bus_i.valid &&
			bus_i.size == `DADC_SZ_32 &&
			bus_i.addr == 24'(st_r.ch[g].comparator_address_value - 24'h3)
			|=> match_o[g])
			else $error("32-bit access covering byte missed");
		a_event_sticky: // see [R23]
		assert property (@(posedge clk_i) disable iff (!rst_b_i)
			match_o[g] |-> st_r.sticky[g])
			else $error("match event not recorded");
		if (DATA_CH_MASK[g])
		begin : g_data
			a_addr_only: // see [R15]
			assert property (@(posedge clk_i) disable iff (!rst_b_i)
				st_r.ch[g].comparator_enable &&
				!st_r.ch[g].opcode_match_select &&
				!st_r.ch[g].direction_qualify_enable &&
				!st_r.ch[g].mismatch_mode_select &&
				st_r.ch[g].data_compare_mask == '0 && bus_i.valid &&
				bus_i.size == `DADC_SZ_8 &&
				bus_i.addr == st_r.ch[g].comparator_address_value
				|=> match_o[g])
				else $error("address-only match missed");
			a_full_field: // see [R12]
			assert property (@(posedge clk_i) disable iff (!rst_b_i)
				!st_r.ch[g].opcode_match_select &&
				!st_r.ch[g].mismatch_mode_select &&
				st_r.ch[g].data_compare_mask == 32'hffffffff &&
				bus_i.valid && bus_i.size != `DADC_SZ_32
				|=> !match_o[g])
				else $error("narrow access matched full field");
			a_diff_nomask: // see [R17]
			assert property (@(posedge clk_i) disable iff (!rst_b_i)
				!st_r.ch[g].opcode_match_select &&
				st_r.ch[g].mismatch_mode_select &&
				st_r.ch[g].data_compare_mask == '0
				|=> !match_o[g])
				else $error("difference match with empty mask");
		end
	end

endmodule

//--- logic/dadc_defs.svh
// constants for the debug address/data comparator: map, fields, resets
// assumes inclusion by the package and the comparator module
`ifndef DADC_DEFS_SVH
`define DADC_DEFS_SVH

`define DADC_MAX_CH 4
`define DADC_AW 24
`define DADC_DW 32
`define DADC_PAW 8
`define DADC_DATA_CH 4'h5

// access size codes
`define DADC_SZ_8 2'h0
`define DADC_SZ_16 2'h1
`define DADC_SZ_32 2'h2

// register select inside a channel block, paddr[3:2]
`define DADC_REG_CTL 2'h0
`define DADC_REG_ADDR 2'h1
`define DADC_REG_DATA 2'h2
`define DADC_REG_MASK 2'h3
`define DADC_OFS_STATUS 8'h40

// control register bit positions
`define DADC_CTL_EN 0
`define DADC_CTL_OPC 1
`define DADC_CTL_DQE 2
`define DADC_CTL_DSEL 3
`define DADC_CTL_MISM 4

// reset values
`define DADC_RST_ADDR 24'h000000
`define DADC_RST_DATA 32'h00000000
`define DADC_RST_MASK 32'h00000000

`endif

//--- logic/dadc_pkg.sv
// types shared by the debug address/data comparator
// assumes dadc_defs.svh sits on the include path
package dadc_pkg;
`include "dadc_defs.svh"

	typedef struct packed {
		logic comparator_enable;
		logic opcode_match_select;
		logic direction_qualify_enable;
		logic direction_select;
		logic mismatch_mode_select;
		logic [`DADC_AW-1:0] comparator_address_value;
		logic [0:3][7:0] data_compare_byte;
		logic [0:3][7:0] data_compare_mask;
	} dadc_cfg_t;

	// monitored data access; data right-justified, lowest address in msb
	typedef struct packed {
		logic valid;
		logic write;
		logic [1:0] size;
		logic [`DADC_AW-1:0] addr;
		logic [`DADC_DW-1:0] data;
	} dadc_bus_t;

	// opcode reaching the execution stage
	typedef struct packed {
		logic valid;
		logic [`DADC_AW-1:0] addr;
	} dadc_pc_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`DADC_PAW-1:0] paddr;
		logic [`DADC_DW-1:0] pwdata;
	} dadc_apb_req_t;

	typedef struct packed {
		dadc_cfg_t [`DADC_MAX_CH-1:0] ch;
		logic [`DADC_MAX_CH-1:0] match;
		logic [`DADC_MAX_CH-1:0] sticky;
		logic [`DADC_DW-1:0] prdata;
	} dadc_state_t;

endpackage

//--- verif/dadc_cpu_model.sv
// core bus model: monitored data accesses and opcode events
// assumes callers wait for each call to return before the next
`timescale 1ns/10ps
module dadc_cpu_model
	import dadc_pkg::*;
(
	input wire logic clk_i,
	output dadc_bus_t bus_o,
	output dadc_pc_t pc_o
);
	initial
	begin
		bus_o = '0;
		pc_o = '0;
	end

	// released lines except size show the inverse, so no stale value looks valid
	task automatic access(input logic w, input logic [1:0] sz,
		input logic [23:0] a, input logic [31:0] d);
		@(posedge clk_i);
		bus_o <= {1'b1, w, sz, a, d};
		@(posedge clk_i);
		bus_o <= {1'b0, ~w, sz, ~a, ~d};
	endtask

	task automatic fetch(input logic [23:0] a);
		@(posedge clk_i);
		pc_o <= {1'b1, a};
		@(posedge clk_i);
		pc_o <= {1'b0, ~a};
	endtask
endmodule

//--- verif/dadc_comparator_test.sv
// self-checking bench for the comparator bank
// assumes dadc_cpu_model stands for the monitored core
`timescale 1ns/10ps
`include "dadc_defs.svh"
module dadc_comparator_test
	import dadc_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	dadc_apb_req_t apb_i = '0;
	dadc_bus_t bus_i;
	dadc_pc_t pc_i;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic [3:0] match_o;
	logic [31:0] rd;
	logic er;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;

	always #4 clk_i = ~clk_i;

	dadc_comparator dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i),
		.pc_i(pc_i), .apb_i(apb_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .match_o(match_o));
	dadc_cpu_model cpu (.clk_i(clk_i), .bus_o(bus_i), .pc_o(pc_i));

	// ****
	// shared tasks
	// ****
	task automatic stop_test;
		$display("errors %0d compared %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		apb_i <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_i);
		apb_i.penable <= 1'b1;
		do
			@(posedge clk_i);
		while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		apb_i.psel <= 1'b0;
		apb_i.penable <= 1'b0;
	endtask

	task automatic prog(input logic [1:0] ch, input logic [4:0] c,
		input logic [23:0] a, input logic [31:0] d, input logic [31:0] m);
		apb(1'b1, {2'h0, ch, 4'h0}, {27'h0, c});
		apb(1'b1, {2'h0, ch, 4'h4}, {8'h00, a});
		apb(1'b1, {2'h0, ch, 4'h8}, d);
		apb(1'b1, {2'h0, ch, 4'hc}, m);
	endtask

	task automatic acc(input logic w, input logic [1:0] sz,
		input logic [23:0] a, input logic [31:0] d, input logic [3:0] e);
		cpu.access(w, sz, a, d);
		#1 cmp("match", {28'h0, e}, {28'h0, match_o});
	endtask

	// channel 0 at 0x000100 plus offset, always enabled
	task automatic dchk(input logic n, input logic [1:0] ao,
		input logic [31:0] d, input logic [31:0] m, input logic [1:0] sz,
		input logic [1:0] bo, input logic [31:0] bd, input logic e);
		prog(2'h0, {n, 4'h1}, {22'h000040, ao}, d, m);
		acc(1'b0, sz, {22'h000040, bo}, bd, {3'h0, e});
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_reset;
		acc(1'b1, `DADC_SZ_8, 24'h000000, 32'h0, 4'h0);
		apb(1'b0, 8'h00, 32'h0);
		cmp("ctl0", 32'h0, rd);
		apb(1'b0, 8'h44, 32'h0);
		cmp("slverr", 32'h1, {31'h0, er});
	endtask

	task automatic t_exact;
		prog(2'h1, 5'h01, 24'h812345, 32'h0, 32'h0);
		acc(1'b0, `DADC_SZ_8, 24'h812345, 32'h0, 4'h2);
		@(posedge clk_i);
		#1 cmp("pulse", 32'h0, {28'h0, match_o});
		acc(1'b1, `DADC_SZ_8, 24'h812346, 32'h0, 4'h0);
		acc(1'b1, `DADC_SZ_16, 24'h812344, 32'h0, 4'h2);
		acc(1'b0, `DADC_SZ_16, 24'h812345, 32'h0, 4'h2);
		acc(1'b0, `DADC_SZ_32, 24'h812342, 32'h0, 4'h2);
		acc(1'b0, `DADC_SZ_32, 24'h812343, 32'h0, 4'h2);
		acc(1'b0, `DADC_SZ_32, 24'h812346, 32'h0, 4'h0);
		acc(1'b0, 2'h3, 24'h812345, 32'h0, 4'h0);
		acc(1'b0, `DADC_SZ_8, 24'h012345, 32'h0, 4'h0);
	endtask

	task automatic t_dir;
		for (int k = 0; k < 4; k++)
		begin
			prog(2'h1, {1'b0, k[1], 3'h5}, 24'h000300, 32'h0, 32'h0);
			acc(k[0], `DADC_SZ_8, 24'h000300, 32'h0,
				{2'h0, k[1] ^ k[0], 1'h0});
		end
	endtask

	task automatic t_opc;
		prog(2'h2, 5'h0f, 24'h000405, 32'h55, '1);
		acc(1'b0, `DADC_SZ_8, 24'h000405, 32'h55, 4'h0);
		cpu.fetch(24'h000405);
		#1 cmp("opcode", 32'h4, {28'h0, match_o});
		cpu.fetch(24'h000406);
		#1 cmp("opcode", 32'h0, {28'h0, match_o});
	endtask

	task automatic t_data;
		dchk(1'h0, 2'h0, 32'h11223344, '1, 2'h2, 2'h0, 32'h11223344,
			1'h1);
		dchk(1'h0, 2'h0, 32'h11223344, '1, 2'h1, 2'h0, 32'h1122,
			1'h0);
		dchk(1'h0, 2'h0, 32'h11223344, '1, 2'h2, 2'h0, 32'h11223345,
			1'h0);
		dchk(1'h0, 2'h1, 32'h220000, 32'hff0000, 2'h0, 2'h1, 32'h22,
			1'h1);
		dchk(1'h0, 2'h1, 32'h220000, 32'hff0000, 2'h2, 2'h0, 32'h99229999,
			1'h1);
		dchk(1'h0, 2'h1, 32'h220000, 32'hff0000, 2'h0, 2'h1, 32'h23,
			1'h0);
		// a word-crossing access is judged part by part
		dchk(1'h0, 2'h3, 32'haa0000bb, 32'h000000ff, 2'h1, 2'h3, 32'hbbaa,
			1'h1);
		dchk(1'h0, 2'h3, 32'haa0000bb, 32'h000000ff, 2'h1, 2'h3, 32'hbcaa,
			1'h0);
		prog(2'h0, 5'h01, 24'h000104, 32'haa000000, 32'hff000000);
		acc(1'b0, `DADC_SZ_16, 24'h000103, 32'hbbaa, 4'h1);
		acc(1'b0, `DADC_SZ_16, 24'h000103, 32'hbbab, 4'h0);
		dchk(1'h0, 2'h0, 32'h0, 32'h0, 2'h0, 2'h0, 32'h5a, 1'h1);
		dchk(1'h1, 2'h0, 32'h0, 32'h0, 2'h0, 2'h0, 32'h5a, 1'h0);
		dchk(1'h1, 2'h0, 32'h11000000, 32'hff000000, 2'h0, 2'h0, 32'h12,
			1'h1);
		dchk(1'h1, 2'h0, 32'h11000000, 32'hff000000, 2'h0, 2'h0, 32'h11,
			1'h0);
		dchk(1'h1, 2'h0, 32'h11223344, '1, 2'h0, 2'h0, 32'h11,
			1'h0);
	endtask

	// even channels address-only; odd ones get mode and mask they lack
	task automatic t_all;
		for (int k = 0; k < 4; k++)
			prog(k[1:0], 5'h01 ^ {k[0], 4'h0}, 24'h000200, '1, {32{k[0]}});
		acc(1'b0, `DADC_SZ_8, 24'h000200, 32'h5, 4'hf);
		apb(1'b0, 8'h40, 32'h0);
		cmp("status", 32'hf, rd);
		apb(1'b1, 8'h40, 32'hf);
		apb(1'b0, 8'h40, 32'h0);
		cmp("status", 32'h0, rd);
		apb(1'b0, 8'h18, 32'h0);
		cmp("data1", 32'h0, rd);
		apb(1'b0, 8'h10, 32'h0);
		cmp("ctl1", 32'h1, rd);
		apb(1'b1, 8'h24, 32'h000201);
		acc(1'b1, `DADC_SZ_8, 24'h000200, 32'h5, 4'hb);
		apb(1'b0, 8'h40, 32'h0);
		cmp("status", 32'hb, rd);
	endtask

	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_total++;
			stop_test;
		end
	end

	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_reset;
		t_exact;
		t_dir;
		t_opc;
		t_data;
		t_all;
		stop_test;
	end
endmodule
